// *** rtl/bridge_gate_pkg.sv ***
// Constants, types and state codes for the bridge gate-drive timing block.
// Assumes one 250 MHz system clock and a synchronous active-high reset.
// How it works
// - One six-bit dead-time setting, n times 50 ns, minimum 100 ns, for all legs.
// - Dead time is counted in system clock cycles derived from the setting.
// - Settings 0, 1 and 2 all give the 100 ns minimum dead time.
// - After either switch of a leg turns off, wait dead time before complement on.
// - Low-side gate output high turns the N-channel switch on, low turns it off.
// - High-side gate output is active low: low turns P-channel on.
// - By default the PWM leg switches in anti-phase with dead time, slow decay.
// - Code 11 turns every bridge switch off during PWM off-time, fast decay.
// - Code 10 recirculates through the low-side switches in every off-time.
// - Code 01 recirculates through the high-side switches in every off-time.
// - Code 00 with falling back-EMF: low side from step start, high after crossing.
// - Code 00 with rising back-EMF: high side from step start, low after crossing.
// - The zero-crossing comparator output is digitally filtered before use.
// - After reset the recirculation selection holds code 00, automatic mixed.
package bridge_gate_pkg;

  localparam int          CLK_PERIOD_PS    = 4000;
  localparam int          DT_UNIT_PS       = 50000;   // 50 ns per dead-time step
  localparam int          DT_MIN_PS        = 100000;  // 100 ns floor
  localparam int          DT_UNIT_CYC      = (DT_UNIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          DT_MIN_CYC       = (DT_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int          DT_MIN_STEPS     = DT_MIN_PS / DT_UNIT_PS;
  localparam int          DT_CNT_W         = 10;
  localparam int          ZC_FILT_LEN      = 8;       // Agreeing samples for a crossing
  localparam logic [5:0]  DT_RESET         = 6'h02;

  typedef logic [5:0] dead_time_t;

  typedef enum logic [1:0] {
    RECIRC_AUTO = 2'h0,
    RECIRC_HIGH = 2'h1,
    RECIRC_LOW  = 2'h2,
    RECIRC_NONE = 2'h3
  } recirc_e;

  // Drive state of one leg: which switch is commanded on
  typedef enum logic [1:0] {
    LEG_OFF  = 2'h0,
    LEG_HIGH = 2'h1,
    LEG_LOW  = 2'h2
  } leg_cmd_e;

  // Commutation step from the commutation controller
  typedef struct packed {
    logic     step_pulse;     // New commutation step starts
    logic     bemf_rising;    // Expected direction of undriven-phase back-EMF
    leg_cmd_e [2:0] drive;    // Per-phase assignment for this step (HIGH, LOW, OFF)
  } commutation_s;

  // Gate pins of one leg
  typedef struct packed {
    logic high_n;             // Active-low high-side gate
    logic low;                // Active-high low-side gate
  } gate_pair_s;

  typedef enum logic [2:0] {
    DT_IDLE = 3'b001,
    DT_WAIT = 3'b010,
    DT_ON   = 3'b100
  } dt_state_e;

  // Dead time in cycles from the programmed setting
  function automatic logic [DT_CNT_W-1:0] dead_cycles(input dead_time_t n);
    logic [DT_CNT_W-1:0] c;
    c = DT_CNT_W'(n) * DT_CNT_W'(DT_UNIT_CYC);
    if (n <= dead_time_t'(DT_MIN_STEPS)) begin
      c = DT_CNT_W'(DT_MIN_CYC);
    end
    return c;
  endfunction : dead_cycles

endpackage : bridge_gate_pkg

// *** rtl/bridge_gate_pwm_dead_time.sv ***
// Top of the bridge gate-drive timing: recirculation choice, zero-cross filter,
// settings held per PWM period and three dead-time legs.
// Assumes PWM phase, period start and commutation steps come from on-clock logic;
// the raw comparator output arrives asynchronously.
module bridge_gate_pwm_dead_time
  import bridge_gate_pkg::*;
(
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire dead_time_t   dead_time_count_in,
  input  wire recirc_e      recirc_select_in,
  input  wire logic         pwm_on_in,
  input  wire logic         period_start_in,
  input  wire commutation_s commutation_in,
  input  wire logic         zero_cross_raw_in,
  output logic              zero_cross_out,
  output logic [2:0]        high_side_gate_out,
  output logic [2:0]        low_side_gate_out,
  output recirc_e           recirc_active_out
);

  // Settings held for the running PWM period
  recirc_e             recirc_reg;
  logic [DT_CNT_W-1:0] dead_cyc_reg;

  // State of the running commutation step
  logic                rising_reg;
  logic                after_zc_reg;
  leg_cmd_e [2:0]      drive_reg;

  // Comparator path: synchroniser, run-length filter, crossing pulse
  logic [2:0]          zc_sync_reg;
  logic                zc_agree;
  logic                zc_full;
  logic                zc_state_reg;
  logic [3:0]          zc_count_reg;
  logic                zc_pulse_reg;

  // Off-time side and per-leg commands
  logic                use_low;
  recirc_e             side_next;
  recirc_e             side_reg;
  leg_cmd_e [2:0]      leg_cmd;
  gate_pair_s [2:0]    leg_gate;

  // Mixed mode side: falling back-EMF starts low, rising starts high;
  // the side swaps once the step has seen its filtered crossing
  function automatic logic mixed_low_side(input logic rising,
                                          input logic crossed);
    logic low;
    low = rising ? crossed : !crossed;
    return low;
  endfunction : mixed_low_side

  // True when the off-time recirculates through the low-side switches
  function automatic logic recirc_low_side(input recirc_e mode,
                                           input logic    rising,
                                           input logic    crossed);
    logic low;
    case (mode)
      RECIRC_LOW:  low = 1'b1;
      RECIRC_HIGH: low = 1'b0;
      default:     low = mixed_low_side(rising, crossed);
    endcase
    return low;
  endfunction : recirc_low_side

  // Side reported outward; fast decay has no recirculating side
  function automatic recirc_e side_code(input recirc_e mode,
                                        input logic    low);
    recirc_e side;
    if (mode == RECIRC_NONE) begin
      side = RECIRC_NONE;
    end else if (low) begin
      side = RECIRC_LOW;
    end else begin
      side = RECIRC_HIGH;
    end
    return side;
  endfunction : side_code

  // Command for one leg: on-time follows the step, off-time recirculates or opens.
  // An undriven leg stays open in both halves so its back-EMF can be sensed.
  function automatic leg_cmd_e leg_command(input leg_cmd_e drive,
                                           input logic     pwm_on,
                                           input recirc_e  mode,
                                           input logic     low);
    leg_cmd_e cmd;
    if (pwm_on || drive == LEG_OFF) begin
      cmd = drive;
    end else if (mode == RECIRC_NONE) begin
      cmd = LEG_OFF;
    end else if (low) begin
      cmd = LEG_LOW;
    end else begin
      cmd = LEG_HIGH;
    end
    return cmd;
  endfunction : leg_command

  // Dead-time count for the period; latched only at a boundary so that a
  // change never shortens a gap already being counted
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      dead_cyc_reg <= dead_cycles(DT_RESET);
    end else if (period_start_in) begin
      dead_cyc_reg <= dead_cycles(dead_time_count_in);
    end
  end

  // Recirculation mode for the period; automatic mixed after reset
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      recirc_reg <= RECIRC_AUTO;
    end else if (period_start_in) begin
      recirc_reg <= recirc_select_in;
    end
  end

  // Comparator synchroniser: three stages; the last two must agree
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      zc_sync_reg <= '0;
    end else begin
      zc_sync_reg <= {zc_sync_reg[1:0], zero_cross_raw_in};
    end
  end

  // A sample counts only when settled and different from the accepted level
  assign zc_agree = (zc_sync_reg[2] == zc_sync_reg[1]) && (zc_sync_reg[2] != zc_state_reg);
  assign zc_full  = (zc_count_reg == 4'(ZC_FILT_LEN - 1));

  // Run length of agreeing samples; any disagreement starts over, so
  // noise shorter than the filter never reaches the commutation logic
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      zc_count_reg <= '0;
    end else if (!zc_agree || zc_full) begin
      zc_count_reg <= '0;
    end else begin
      zc_count_reg <= zc_count_reg + 4'h1;
    end
  end

  // Accepted comparator level, updated after a full run
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      zc_state_reg <= 1'b0;
    end else if (zc_agree && zc_full) begin
      zc_state_reg <= zc_sync_reg[2];
    end
  end

  // One-cycle crossing pulse on each accepted change
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      zc_pulse_reg <= 1'b0;
    end else begin
      zc_pulse_reg <= zc_agree && zc_full;
    end
  end

  assign zero_cross_out = zc_pulse_reg;

  // Expected back-EMF direction of the running step
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rising_reg <= 1'b0;
    end else if (commutation_in.step_pulse) begin
      rising_reg <= commutation_in.bemf_rising;
    end
  end

  // Crossing seen in this step; a new step clears it, but a crossing in the
  // same cycle as a step is kept so that no accepted crossing is lost
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      after_zc_reg <= 1'b0;
    end else if (zc_pulse_reg) begin
      after_zc_reg <= 1'b1;
    end else if (commutation_in.step_pulse) begin
      after_zc_reg <= 1'b0;
    end
  end

  // Per-phase drive of the running step; all legs open until the first step
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      drive_reg <= '{default: LEG_OFF};
    end else if (commutation_in.step_pulse) begin
      drive_reg <= commutation_in.drive;
    end
  end

  // Off-time side from mode, direction and crossing
  always_comb begin
    use_low   = recirc_low_side(recirc_reg, rising_reg, after_zc_reg);
    side_next = side_code(recirc_reg, use_low);
  end

  // Registered side report; after reset auto mode starts on the low side
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      side_reg <= RECIRC_LOW;
    end else begin
      side_reg <= side_next;
    end
  end

  assign recirc_active_out = side_reg;

  // Leg commands; a change here starts that leg's dead-time count
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      leg_cmd[i] = leg_command(drive_reg[i], pwm_on_in, recirc_reg, use_low);
    end
  end

  // One dead-time leg per phase, sharing the single setting
  for (genvar g = 0; g < 3; g++) begin : g_leg
    leg_dead_time u_leg (
      .clk_in      (clk_in),
      .rst_in      (rst_in),
      .cmd_in      (leg_cmd[g]),
      .dead_cyc_in (dead_cyc_reg),
      .gate_out    (leg_gate[g])
    );
    assign high_side_gate_out[g] = leg_gate[g].high_n;
    assign low_side_gate_out[g]  = leg_gate[g].low;
  end

endmodule : bridge_gate_pwm_dead_time

// *** rtl/leg_dead_time.sv ***
// One bridge leg: takes a commanded state and inserts dead time on every change.
// Assumes the command and dead-time count come from logic on the same clock.
module leg_dead_time
  import bridge_gate_pkg::*;
(
  input  wire logic                clk_in,
  input  wire logic                rst_in,
  input  wire leg_cmd_e            cmd_in,
  input  wire logic [DT_CNT_W-1:0] dead_cyc_in,
  output gate_pair_s               gate_out
);

  dt_state_e           state_reg;
  leg_cmd_e            target_reg;
  logic [DT_CNT_W-1:0] count_reg;

  // Leaving a switch drops to all-off, counts dead time, then turns on target
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg  <= DT_IDLE;
      target_reg <= LEG_OFF;
      count_reg  <= '0;
    end else begin
      case (state_reg)
        DT_IDLE, DT_ON: begin
          if (cmd_in != target_reg) begin
            target_reg <= cmd_in;
            count_reg  <= dead_cyc_in;
            state_reg  <= DT_WAIT;
          end
        end
        DT_WAIT: begin
          if (cmd_in != target_reg) begin
            target_reg <= cmd_in;                       // Restart on retarget
            count_reg  <= dead_cyc_in;
          end else if (count_reg <= DT_CNT_W'(1)) begin
            state_reg <= DT_ON;
          end else begin
            count_reg <= count_reg - DT_CNT_W'(1);
          end
        end
        default: state_reg <= DT_IDLE;
      endcase
    end
  end

  // Registered gate pins; both off during reset and dead time
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      gate_out <= '{high_n: 1'b1, low: 1'b0};
    end else begin
      gate_out.high_n <= !(state_reg == DT_ON && target_reg == LEG_HIGH);
      gate_out.low    <=  (state_reg == DT_ON && target_reg == LEG_LOW);
    end
  end

endmodule : leg_dead_time

// *** verification/bridge_gate_properties.sv ***
// Checker bound to the bridge gate-drive top.
// Assumes one clock with a synchronous active-high reset.
module bridge_gate_checker
  import bridge_gate_pkg::*;
(
  input wire logic       clk_in,
  input wire logic       rst_in,
  input wire logic       pwm_on_in,
  input wire logic       zero_cross_raw_in,
  input wire logic       zero_cross_out,
  input wire logic [2:0] high_side_gate_out,
  input wire logic [2:0] low_side_gate_out,
  input wire recirc_e    recirc_active_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [5:0] hi_off_reg;
  logic [5:0] lo_off_reg;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Cycles each leg-0 switch has stood off; saturates, so reset means long off
  always_ff @(posedge clk_in) begin
    hi_off_reg <= rst_in ? 6'h3f : high_side_gate_out[0] ? hi_off_reg + 6'(~&hi_off_reg) : 6'h00;
    lo_off_reg <= rst_in ? 6'h3f : !low_side_gate_out[0] ? lo_off_reg + 6'(~&lo_off_reg) : 6'h00;
  end
  AST_NO_SHOOT: assert property ((low_side_gate_out & ~high_side_gate_out) == 3'h0)
    else $error("both switches of a leg on");
  AST_LOW_DEAD: assert property ($rose(low_side_gate_out[0]) |-> hi_off_reg >= 6'h19)
    else $error("dead time too short");
  AST_HIGH_DEAD: assert property ($fell(high_side_gate_out[0]) |-> lo_off_reg >= 6'h19)
    else $error("dead time too short");
  AST_FAST: assert property ((recirc_active_out == RECIRC_NONE && !pwm_on_in) [*4]
    |-> {high_side_gate_out, low_side_gate_out} == 6'h38) else $error("switch on in fast decay");
  AST_LOW_SIDE: assert property ((recirc_active_out == RECIRC_LOW && !pwm_on_in) [*4]
    |-> high_side_gate_out == 3'h7) else $error("high side on in low recirculation");
  AST_HIGH_SIDE: assert property ((recirc_active_out == RECIRC_HIGH && !pwm_on_in) [*4]
    |-> low_side_gate_out == 3'h0) else $error("low side on in high recirculation");
  AST_ZC_ONE: assert property (zero_cross_out |=> !zero_cross_out)
    else $error("crossing pulse too long");
  AST_ZC_FILT: assert property (zero_cross_out
    |-> $past(zero_cross_raw_in, 4) == $past(zero_cross_raw_in, 9)) else $error("unfiltered");
  cover property (recirc_active_out == RECIRC_NONE && !pwm_on_in);
  cover property (zero_cross_out);
  cover property ($rose(low_side_gate_out[0]));
endmodule : bridge_gate_checker

bind bridge_gate_pwm_dead_time bridge_gate_checker u_checker (.clk_in(clk_in), .rst_in(rst_in),
  .pwm_on_in(pwm_on_in), .zero_cross_raw_in(zero_cross_raw_in), .zero_cross_out(zero_cross_out),
  .high_side_gate_out(high_side_gate_out), .low_side_gate_out(low_side_gate_out),
  .recirc_active_out(recirc_active_out));

// *** verification/bridge_gate_pwm_dead_time_test.sv ***
// Self-checking bench for the bridge gate-drive block with a bridge model.
// Assumes package, design, checker and model are compiled first.
module bridge_gate_pwm_dead_time_test
  import bridge_gate_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in = 1'b0, rst_in = 1'b1, pwm_on = 1'b0, p_start = 1'b0, zc_raw = 1'b0;
  logic zc_out, short_out, shorted = 1'b0;
  logic [2:0] high_g, low_g;
  logic [5:0] pat [1:3] = '{6'h20, 6'h3b, 6'h38};
  dead_time_t dt_n = 6'h00;
  recirc_e mode = RECIRC_AUTO, side;
  commutation_s comm = '0;
  int seed = 63, n_fail = 0, n_compared = 0, gap, e, n_zc = 0;
  // Clock, a sticky record of any shorted leg and a count of crossing pulses
  always #2 clk_in = ~clk_in;
  always @(posedge clk_in) shorted |= (short_out === 1'b1);
  always @(posedge clk_in) n_zc += (zc_out === 1'b1);
  bridge_gate_pwm_dead_time u_dut (.clk_in(clk_in), .rst_in(rst_in), .dead_time_count_in(dt_n),
    .recirc_select_in(mode), .pwm_on_in(pwm_on), .period_start_in(p_start),
    .commutation_in(comm), .zero_cross_raw_in(zc_raw), .zero_cross_out(zc_out),
    .high_side_gate_out(high_g), .low_side_gate_out(low_g), .recirc_active_out(side));
  fet_bridge_model u_bridge (.high_gate_in(high_g), .low_gate_in(low_g), .short_out(short_out));
  function automatic int exp_dead(input dead_time_t n);
    return (n <= 6'h02) ? 25 : n * 13;
  endfunction : exp_dead
  task automatic tick(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask : tick
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic cfg(input recirc_e m);
    mode = m;
    p_start = 1'b1;
    tick(1);
    p_start = 1'b0;
  endtask : cfg
  task automatic step(input logic rising);
    comm = {1'b1, rising, LEG_OFF, LEG_LOW, LEG_HIGH};
    tick(1);
    comm.step_pulse = 1'b0;
    tick(2);
  endtask : step
  task automatic give_verdict();
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  initial begin
    #200_000;
    n_fail++;
    give_verdict();
  end
  initial begin
    tick(4);
    rst_in = 1'b0;
    check({high_g, low_g}, 6'h38);
    // Mixed mode from reset: a glitch is ignored, crossings and steps flip the side
    step(1'b0);
    zc_raw = 1'b1;
    tick(3);
    zc_raw = 1'b0;
    tick(60);
    check(side, RECIRC_LOW);
    zc_raw = 1'b1;
    tick(60);
    check(side, RECIRC_HIGH);
    step(1'b0);
    check(side, RECIRC_LOW);
    step(1'b1);
    check(side, RECIRC_HIGH);
    zc_raw = 1'b0;
    tick(60);
    check({side, high_g, low_g}, {RECIRC_LOW, 6'h3b});
    check(n_zc, 2);
    $display("mixed mode test done");
    // Dead time on leg B, corners then random settings
    for (int i = 0; i < 9; i++) begin
      dt_n = (i < 4) ? 6'(i) : (i == 4) ? 6'h3f : 6'($random(seed));
      cfg(RECIRC_HIGH);
      pwm_on = 1'b1;
      tick(900);
      check({high_g, low_g}, 6'h32);
      pwm_on = 1'b0;
      for (gap = 0; gap < 99 && low_g[1] !== 1'b0; gap++) tick(1);
      for (gap = 0; gap < 999 && high_g[1] !== 1'b0; gap++) tick(1);
      e = exp_dead(dt_n);
      check(gap, e);
      tick(4);
      check({high_g, low_g}, 6'h20);
      $display("dead time %0d test done", dt_n);
    end
    // Fixed modes; a setting changed between boundaries is ignored
    dt_n = 6'h03;
    for (int m = 1; m < 4; m++) begin
      cfg(recirc_e'(m));
      pwm_on = 1'b1;
      tick(60 + ($random(seed) & 63));
      pwm_on = 1'b0;
      tick(60);
      check({side, high_g, low_g}, {2'(m), pat[m]});
      mode = RECIRC_AUTO;
      tick(9);
      check(side, m);
      $display("mode %0d test done", m);
    end
    // Reset in mid-run: gates open and the mode falls back to automatic mixed
    rst_in = 1'b1;
    tick(4);
    rst_in = 1'b0;
    check({side, high_g, low_g}, {RECIRC_LOW, 6'h38});
    $display("reset test done");
    check(shorted, 1'b0);
    give_verdict();
  end
endmodule : bridge_gate_pwm_dead_time_test

// *** verification/fet_bridge_model.sv ***
// Model of the external P/N MOSFET bridge on the gate outputs.
// Assumes gate levels reach the switches directly; flags a shorted leg.
module fet_bridge_model (
  input  wire logic [2:0] high_gate_in,
  input  wire logic [2:0] low_gate_in,
  output logic            short_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // P-channel conducts on a low gate, N-channel on a high gate
  assign short_out = |(~high_gate_in & low_gate_in);
endmodule : fet_bridge_model
